// File: hdl/sbe_pkg.sv
// Purpose: Shared constants for the serial bit array programming port.
// Assumes: Operating clock ref_clk at 125 MHz.
// Notes: The erase count is derived from the required time and the clock rate; drive counts are given in cycles.
package sbe_pkg;

  // ==========================================================================
  // Array geometry
  localparam int ARRAY_BITS = 128;
  localparam int ADDR_W = 8;
  localparam logic ERASED_BIT = 1'h0;

  // ==========================================================================
  // Select patterns, second bit then third bit
  localparam logic [1:0] SEL_PROG = 2'h0;
  localparam logic [1:0] SEL_READ = 2'h1;
  localparam logic [1:0] SEL_NONE = 2'h2;
  localparam logic [1:0] SEL_ERASE = 2'h3;
  localparam logic [1:0] SEL_CNT_FIRST = 2'h0;
  localparam logic [1:0] SEL_CNT_SECOND = 2'h1;
  localparam logic [1:0] SEL_CNT_THIRD = 2'h2;

  // ==========================================================================
  // Timing
  localparam int REF_CLK_KHZ = 125000;
  localparam int ERASE_TIME_MS = 30;
  localparam int ERASE_CYC_DEF = ERASE_TIME_MS * REF_CLK_KHZ;
  localparam int ERASE_CNT_W = 22;
  localparam int OUT_DRIVE_MIN_CYC = 4;
  localparam int OUT_DRIVE_MAX_CYC = 8;
  localparam int SYNC_LAT_CYC = 3;
  localparam logic [3:0] DRV_WAIT_CYC = 4'(OUT_DRIVE_MIN_CYC - SYNC_LAT_CYC);

  // ==========================================================================
  // Sequencer states
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_SEL   = 6'h02,
    ST_PROG  = 6'h04,
    ST_READ  = 6'h08,
    ST_ERASE = 6'h10,
    ST_HOLD  = 6'h20
  } sbe_state_t;

endpackage

// File: hdl/sbe_sync.sv
// Purpose: Two flip-flop synchroniser for levels entering the ref_clk domain.
// Assumes: Each bit is an independent level.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ns
module sbe_sync import sbe_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule

// File: hdl/sbe_port.sv
// Purpose: Serial program, read and bulk erase port of a 128-bit bit array.
// Assumes: sel_clk is the programmer's select clock; reset_pin_n frames sequences.
// Notes: Array contents survive reset_pin_n; rst_n models power-on.
`timescale 1ns/1ns

module sbe_port import sbe_pkg::*; #(
  parameter int unsigned ERASE_CYCLES = ERASE_CYC_DEF
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sel_clk,
  input wire logic reset_pin_n,
  input wire logic serial_data_pin_i,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe,
  output logic erase_active
);

  localparam logic [ERASE_CNT_W-1:0] ERASE_LAST = ERASE_CNT_W'(ERASE_CYCLES - 1);

  // ==========================================================================
  // Link domain: capture at each select fall
  logic lk_bit_ff;
  logic lk_tog_ff;
  logic nxt_lk_bit;
  logic nxt_lk_tog;

  always_comb begin
    nxt_lk_bit = serial_data_pin_i;
    nxt_lk_tog = ~lk_tog_ff;
  end

  // The select clock stops outside frames, so the pin reset clears it directly.
  always_ff @(negedge sel_clk or negedge reset_pin_n) begin
    if (!reset_pin_n) begin
      lk_bit_ff <= 1'h0;
      lk_tog_ff <= 1'h0;
    end else begin
      lk_bit_ff <= nxt_lk_bit;
      lk_tog_ff <= nxt_lk_tog;
    end
  end

  // ==========================================================================
  // Crossing into ref_clk
  logic [2:0] sync_vec;
  logic sel_sync;
  logic pin_rst_n_sync;
  logic tog_sync;

  sbe_sync #(.WIDTH(3)) u_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .din({sel_clk, reset_pin_n, lk_tog_ff}),
    .dout(sync_vec)
  );

  assign sel_sync = sync_vec[2];
  assign pin_rst_n_sync = sync_vec[1];
  assign tog_sync = sync_vec[0];

  // ==========================================================================
  // Sequencer
  sbe_state_t state_ff;
  sbe_state_t nxt_state;
  logic [1:0] sel_cnt_ff;
  logic [1:0] nxt_sel_cnt;
  logic sel_b1_ff;
  logic nxt_sel_b1;
  logic [ADDR_W-1:0] addr_ff;
  logic [ADDR_W-1:0] nxt_addr;
  logic tog_seen_ff;
  logic sel_prev_ff;
  logic drv_pend_ff;
  logic nxt_drv_pend;
  logic [3:0] drv_cnt_ff;
  logic [3:0] nxt_drv_cnt;
  logic data_o_ff;
  logic nxt_data_o;
  logic data_oe_ff;
  logic nxt_data_oe;
  logic erase_ff;
  logic nxt_erase;
  logic [ERASE_CNT_W-1:0] erase_cnt_ff;
  logic [ERASE_CNT_W-1:0] nxt_erase_cnt;
  logic [ARRAY_BITS-1:0] mem_ff;
  logic [ARRAY_BITS-1:0] nxt_mem;
  logic fall_ev;
  logic rise_ev;
  logic addr_done;

  // The captured bit is stable for at least 16 cycles after the fall, longer
  // than the toggle takes to cross, so it is read here without its own sync.
  assign fall_ev = tog_sync ^ tog_seen_ff;
  assign rise_ev = sel_sync & ~sel_prev_ff;
  assign addr_done = addr_ff[ADDR_W-1];

  always_comb begin
    nxt_state = state_ff;
    nxt_sel_cnt = sel_cnt_ff;
    nxt_sel_b1 = sel_b1_ff;
    nxt_addr = addr_ff;
    nxt_drv_pend = drv_pend_ff;
    nxt_drv_cnt = drv_cnt_ff;
    nxt_data_o = data_o_ff;
    nxt_data_oe = data_oe_ff;
    nxt_erase = erase_ff;
    nxt_erase_cnt = erase_cnt_ff;
    nxt_mem = mem_ff;
    if (!pin_rst_n_sync) begin
      // Reset low ends any sequence, complete or not.
      nxt_state = ST_IDLE;
      nxt_sel_cnt = SEL_CNT_FIRST;
      nxt_addr = '0;
      nxt_drv_pend = 1'h0;
      nxt_data_oe = 1'h0;
      nxt_erase = 1'h0;
      nxt_erase_cnt = '0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          nxt_state = ST_SEL;
        end
        ST_SEL: begin
          if (fall_ev) begin
            unique case (sel_cnt_ff)
              SEL_CNT_FIRST: nxt_sel_cnt = SEL_CNT_SECOND;
              SEL_CNT_SECOND: begin
                nxt_sel_b1 = lk_bit_ff;
                nxt_sel_cnt = SEL_CNT_THIRD;
              end
              default: begin
                unique case ({sel_b1_ff, lk_bit_ff})
                  SEL_PROG: nxt_state = ST_PROG;
                  SEL_READ: nxt_state = ST_READ;
                  SEL_ERASE: begin
                    nxt_state = ST_ERASE;
                    nxt_erase = 1'h1;
                  end
                  SEL_NONE: nxt_state = ST_HOLD;
                endcase
              end
            endcase
          end
        end
        ST_PROG: begin
          if (fall_ev && !addr_done) begin
            nxt_mem[addr_ff[ADDR_W-2:0]] = lk_bit_ff;
            nxt_addr = addr_ff + ADDR_W'(1);
          end
        end
        ST_READ: begin
          if (rise_ev) begin
            nxt_data_oe = 1'h0;
            nxt_drv_pend = ~addr_done;
            nxt_drv_cnt = '0;
          end else if (drv_pend_ff) begin
            nxt_drv_cnt = drv_cnt_ff + 4'h1;
            if (drv_cnt_ff == DRV_WAIT_CYC) begin
              nxt_data_o = mem_ff[addr_ff[ADDR_W-2:0]];
              nxt_data_oe = 1'h1;
              nxt_drv_pend = 1'h0;
            end
          end
          if (fall_ev && !addr_done) begin
            nxt_addr = addr_ff + ADDR_W'(1);
          end
        end
        ST_ERASE: begin
          // Erase runs once started; the programmer's reset ends it early.
          if (erase_cnt_ff == ERASE_LAST) begin
            nxt_mem = {ARRAY_BITS{ERASED_BIT}};
            nxt_erase = 1'h0;
            nxt_state = ST_HOLD;
          end else begin
            nxt_erase_cnt = erase_cnt_ff + ERASE_CNT_W'(1);
          end
        end
        ST_HOLD: begin
          nxt_data_oe = 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      sel_cnt_ff <= SEL_CNT_FIRST;
      sel_b1_ff <= 1'h0;
      addr_ff <= '0;
      tog_seen_ff <= 1'h0;
      sel_prev_ff <= 1'h0;
      drv_pend_ff <= 1'h0;
      drv_cnt_ff <= '0;
      data_o_ff <= 1'h0;
      data_oe_ff <= 1'h0;
      erase_ff <= 1'h0;
      erase_cnt_ff <= '0;
      mem_ff <= {ARRAY_BITS{ERASED_BIT}};
    end else begin
      state_ff <= nxt_state;
      sel_cnt_ff <= nxt_sel_cnt;
      sel_b1_ff <= nxt_sel_b1;
      addr_ff <= nxt_addr;
      tog_seen_ff <= tog_sync;
      sel_prev_ff <= sel_sync;
      drv_pend_ff <= nxt_drv_pend;
      drv_cnt_ff <= nxt_drv_cnt;
      data_o_ff <= nxt_data_o;
      data_oe_ff <= nxt_data_oe;
      erase_ff <= nxt_erase;
      erase_cnt_ff <= nxt_erase_cnt;
      mem_ff <= nxt_mem;
    end
  end

  assign serial_data_pin_o = data_o_ff;
  assign serial_data_pin_oe = data_oe_ff;
  assign erase_active = erase_ff;

endmodule

// File: tb/sbe_port_properties.sv
// Purpose: Assertions on the pins of the serial bit array port.
// Assumes: Bound to every sbe_port instance.
// Notes: Erase length allows two cycles for the reset pin synchroniser.
`timescale 1ns/1ns
module sbe_port_checker import sbe_pkg::*; #(
  parameter int unsigned ERASE_CYCLES = ERASE_CYC_DEF
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sel_clk,
  input wire logic reset_pin_n,
  input wire logic serial_data_pin_i,
  input wire logic serial_data_pin_o,
  input wire logic serial_data_pin_oe,
  input wire logic erase_active
);
  // ==========================================================================
  // Erase length counter and properties
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  always_comb nxt_cnt = erase_active ? cnt_ff + 32'h1 : 32'h0;
  always_ff @(posedge ref_clk) cnt_ff <= rst_n ? nxt_cnt : 32'h0;
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_por; disable iff (1'h0) !rst_n |=> !serial_data_pin_oe && !erase_active; endproperty
  a_por: assert property (p_por) else $error("active in power-on reset");
  property p_pin; !reset_pin_n [*6] |-> !serial_data_pin_oe && !erase_active; endproperty
  a_pin: assert property (p_pin) else $error("active while reset pin low");
  property p_drv; $rose(serial_data_pin_oe) |-> sel_clk && $past(sel_clk, 3); endproperty
  a_drv: assert property (p_drv) else $error("drive too early");
  property p_rel; $rose(sel_clk) |-> ##[0:8] !serial_data_pin_oe; endproperty
  a_rel: assert property (p_rel) else $error("no release");
  property p_ers; $rose(erase_active) |-> !sel_clk && !$past(sel_clk, 3); endproperty
  a_ers: assert property (p_ers) else $error("erase without low select");
  property p_exc; !(erase_active && serial_data_pin_oe); endproperty
  a_exc: assert property (p_exc) else $error("erase and drive together");
  property p_len; erase_active |-> cnt_ff <= 32'(ERASE_CYCLES) + 32'h2; endproperty
  a_len: assert property (p_len) else $error("erase too long");
  property p_hld; serial_data_pin_oe && $past(serial_data_pin_oe) |-> $stable(serial_data_pin_o);
  endproperty
  a_hld: assert property (p_hld) else $error("driven bit changed");
  c_drv: cover property ($rose(serial_data_pin_oe));
  c_ers: cover property ($fell(erase_active) && reset_pin_n);
  c_end: cover property ($fell(reset_pin_n));
endmodule

bind sbe_port sbe_port_checker #(.ERASE_CYCLES(ERASE_CYCLES)) sbe_port_checker_i (.ref_clk,
  .rst_n, .sel_clk, .reset_pin_n, .serial_data_pin_i, .serial_data_pin_o, .serial_data_pin_oe,
  .erase_active);

// File: tb/sbe_prog_model.sv
// Purpose: Programmer model driving the select clock and the data pin.
// Assumes: The bench calls its tasks one after another.
// Notes: Low phases are short because the device does not time cell programming.
`timescale 1ns/1ns
module sbe_prog_model (
  output logic sel_clk,
  output logic host_d,
  output logic host_oe
);
  logic lclk = 1'h0;
  initial begin
    sel_clk = 1'h1;
    host_d = 1'h0;
    host_oe = 1'h1;
    #3;
    forever begin
      #7 lclk = 1'h1;
      #8 lclk = 1'h0;
    end
  end
  task automatic fall(input logic d, input logic drv);
    host_oe = drv;
    host_d = d;
    @(posedge lclk);
    sel_clk = 1'h0;
    repeat (20) @(posedge lclk);
  endtask
  task automatic rise(input logic drv);
    host_oe = drv;
    @(posedge lclk);
    sel_clk = 1'h1;
    repeat (20) @(posedge lclk);
  endtask
  task automatic select(input logic [1:0] b);
    fall(1'h0, 1'h1);
    rise(1'h1);
    fall(b[1], 1'h1);
    rise(1'h1);
    fall(b[0], 1'h1);
  endtask
  task automatic park();
    @(posedge lclk);
    host_oe = 1'h1;
    host_d = 1'h0;
    sel_clk = 1'h1;
  endtask
endmodule

// File: tb/sbe_port_tb.sv
// Purpose: Self-checking bench for the serial bit array port.
// Assumes: Erase time shortened to ERASE_N cycles.
// Notes: An undriven data pin toggles; a missed drive leaves its bit queued and fails the "all reads answered" check.
`timescale 1ns/1ns
`define CHK(n, e, a) begin \
  checked++; \
  if ((e) !== (a)) begin \
    failures++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, a); \
  end \
end
module sbe_port_tb import sbe_pkg::*;;
  localparam int unsigned ERASE_N = 50;
  logic ref_clk, rst_n, reset_pin_n, junk, oe_q, pin, sel_clk, host_d, host_oe;
  logic dev_o, dev_oe, erase_active;
  logic exp_b;
  logic [31:0] rnd;
  logic [ARRAY_BITS-1:0] mem;
  logic exp_q[$];
  int failures, checked, cycles;
  assign pin = host_oe ? host_d : (dev_oe ? dev_o : junk);
  sbe_port #(.ERASE_CYCLES(ERASE_N)) sbe_port_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .sel_clk(sel_clk), .reset_pin_n(reset_pin_n), .serial_data_pin_i(pin),
    .serial_data_pin_o(dev_o), .serial_data_pin_oe(dev_oe), .erase_active(erase_active));
  sbe_prog_model sbe_prog_model_i (.sel_clk(sel_clk), .host_d(host_d), .host_oe(host_oe));
  initial begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic test_done();
    if (failures == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================================================================
  // Monitor compares each new drive with the oldest expected bit
  always @(negedge ref_clk) begin
    junk <= ~junk;
    oe_q <= dev_oe;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      test_done();
    end else if (dev_oe && !oe_q) begin
      if (exp_q.size() == 0) begin
        `CHK("spurious drive", 1'h0, 1'h1)
      end else begin
        // Popped once here, since the macro names its expected value twice.
        exp_b = exp_q.pop_front();
        `CHK("read bit", exp_b, dev_o)
      end
    end
  end
  task automatic frame_end();
    @(negedge ref_clk);
    reset_pin_n = 1'h0;
    sbe_prog_model_i.park();
    repeat (10) @(negedge ref_clk);
    reset_pin_n = 1'h1;
    repeat (12) @(negedge ref_clk);
  endtask
  task automatic prog(input int n);
    sbe_prog_model_i.select(SEL_PROG);
    sbe_prog_model_i.rise(1'h1);
    for (int i = 0; i < n; i++) begin
      rnd = lfsr(rnd);
      mem[i] = rnd[0];
      sbe_prog_model_i.fall(rnd[0], 1'h1);
      if (i < n - 1) sbe_prog_model_i.rise(1'h1);
    end
    frame_end();
  endtask
  task automatic rd(input int n);
    sbe_prog_model_i.select(SEL_READ);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(mem[i]);
      sbe_prog_model_i.rise(1'h0);
      if (i < n - 1) sbe_prog_model_i.fall(1'h0, 1'h0);
    end
    frame_end();
  endtask
  initial begin
    {rst_n, junk, oe_q, failures, checked, cycles} = '0;
    // The pin reset starts high so that a real falling edge clears the link flops.
    reset_pin_n = 1'h1;
    rnd = 32'h3C96F573;
    mem = '0;
    @(negedge ref_clk);
    reset_pin_n = 1'h0;
    repeat (11) @(negedge ref_clk);
    rst_n = 1'h1;
    frame_end();
    rd(4);
    prog(ARRAY_BITS);
    rd(ARRAY_BITS);
    sbe_prog_model_i.select(SEL_ERASE);
    @(negedge ref_clk);
    `CHK("erase start", 1'h1, erase_active)
    repeat (ERASE_N + 20) @(negedge ref_clk);
    `CHK("erase end", 1'h0, erase_active)
    mem = '0;
    frame_end();
    rd(8);
    prog(5);
    rd(7);
    sbe_prog_model_i.select(SEL_NONE);
    sbe_prog_model_i.rise(1'h0);
    sbe_prog_model_i.fall(1'h0, 1'h0);
    sbe_prog_model_i.rise(1'h0);
    frame_end();
    `CHK("all reads answered", 1'h1, exp_q.size() == 0)
    test_done();
  end
endmodule
